// ---- core/otr_pkg.sv ----
package otr_pkg;

   // data width of each port
   localparam int OTR_PORT_W = 8;

   // register byte offsets
   localparam logic [3:0] OTR_CTRL_OFS = 4'h0;
   localparam logic [3:0] OTR_STAT_OFS = 4'h4;
   localparam logic [3:0] OTR_CAPT_OFS = 4'h8;

   // control register field positions
   localparam int OTR_CTRL_OE_N_BIT = 0;
   localparam int OTR_CTRL_DIR_BIT = 1;
   localparam int OTR_CTRL_SAB_BIT = 2;
   localparam int OTR_CTRL_SBA_BIT = 3;
   localparam int OTR_CTRL_W = 4;

   // control reset value: drive disabled, all selects low
   localparam logic [3:0] OTR_CTRL_RST = 4'h1;

   // status register field positions
   localparam int OTR_STAT_QA_LSB = 0;
   localparam int OTR_STAT_QB_LSB = 8;
   localparam int OTR_STAT_PA_LSB = 16;
   localparam int OTR_STAT_PB_LSB = 24;

   // capture strobe register bit positions
   localparam int OTR_CAPT_A_BIT = 0;
   localparam int OTR_CAPT_B_BIT = 1;

   // axi response codes
   localparam logic [1:0] OTR_RESP_OKAY = 2'h0;
   localparam logic [1:0] OTR_RESP_SLVERR = 2'h2;

   // control bits that steer the transceiver
   typedef struct packed {
      logic b_to_a_source_select;
      logic a_to_b_source_select;
      logic direction;
      logic drive_en_n;
   } otr_ctrl_type;

   // one bidirectional port as seen from the core
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } otr_drive_type;

endpackage

// ---- core/otr_transceiver.sv ----
`timescale 1ns/1ps
`default_nettype none

module otr_transceiver
   import otr_pkg::*;
#(
   parameter int PORT_W = OTR_PORT_W
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // capture clock pins, sampled on aclk
   input wire logic a_side_capture_clock,
   input wire logic b_side_capture_clock,
   // port a lines
   input wire logic [PORT_W-1:0] port_a_lines_in,
   output logic [PORT_W-1:0] port_a_lines_out,
   output logic [PORT_W-1:0] port_a_lines_oe,
   // port b lines
   input wire logic [PORT_W-1:0] port_b_lines_in,
   output logic [PORT_W-1:0] port_b_lines_out,
   output logic [PORT_W-1:0] port_b_lines_oe
);

   // rising edge seen between two samples
   function automatic logic rise_seen(input logic now, input logic prev);
      return now & ~prev;
   endfunction

   // source mux: stored contents or live opposite port
   function automatic logic [PORT_W-1:0] pick_src(
      input logic use_store,
      input logic [PORT_W-1:0] stored,
      input logic [PORT_W-1:0] live
   );
      return use_store ? stored : live;
   endfunction

   // control and bus state
   otr_ctrl_type ctrl_r;
   logic cab_prev_r;
   logic cba_prev_r;
   logic [PORT_W-1:0] a_storage_register_r;
   logic [PORT_W-1:0] b_storage_register_r;
   logic aw_have_r;
   logic w_have_r;
   logic [3:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [1:0] rresp_r;
   logic [31:0] rdata_r;

   // decoded wires
   wire logic aw_take;
   wire logic w_take;
   wire logic ar_take;
   wire logic wr_do;
   wire logic wr_ctrl_hit;
   wire logic wr_capt_hit;
   wire logic wr_stat_hit;
   wire logic wr_mapped;
   wire logic rd_mapped;
   wire logic sw_cap_a;
   wire logic sw_cap_b;
   wire logic load_a;
   wire logic load_b;
   wire logic drive_on;
   wire logic drive_b;
   wire logic drive_a;
   wire logic [31:0] stat_word;
   wire logic [31:0] rd_word;
   wire logic [3:0] ctrl_wr_val;
   wire logic ctrl_we;
   wire logic cab_rise;
   wire logic cba_rise;
   wire logic rd_ctrl_hit;
   wire logic rd_stat_hit;
   wire logic rd_capt_hit;
   wire logic [PORT_W-1:0] b_src;
   wire logic [PORT_W-1:0] a_src;
   wire logic [1:0] bresp_nxt;
   wire logic [1:0] rresp_nxt;

   // axi handshake decode
   // one write and one read at a time; readies fall while held
   assign s_axi_awready = ~aw_have_r & ~bvalid_r;
   assign s_axi_wready = ~w_have_r & ~bvalid_r;
   assign s_axi_arready = ~rvalid_r;
   assign aw_take = s_axi_awvalid & s_axi_awready;
   assign w_take = s_axi_wvalid & s_axi_wready;
   assign ar_take = s_axi_arvalid & s_axi_arready;
   assign wr_do = aw_have_r & w_have_r & ~bvalid_r;

   // write address decode, word aligned
   assign wr_ctrl_hit = awaddr_r == OTR_CTRL_OFS;
   assign wr_stat_hit = awaddr_r == OTR_STAT_OFS;
   assign wr_capt_hit = awaddr_r == OTR_CAPT_OFS;
   assign wr_mapped = wr_ctrl_hit | wr_stat_hit | wr_capt_hit;
   assign ctrl_wr_val = wdata_r[OTR_CTRL_W-1:0];

   // control bits change only with byte lane 0 enabled
   assign ctrl_we = wr_do & wr_ctrl_hit & wstrb_r[0];
   assign bresp_nxt = wr_mapped ? OTR_RESP_OKAY : OTR_RESP_SLVERR;

   // software capture strobes, one cycle
   // these share the load path with the pin edges
   assign sw_cap_a = wr_do & wr_capt_hit & wstrb_r[0]
      & wdata_r[OTR_CAPT_A_BIT];
   assign sw_cap_b = wr_do & wr_capt_hit & wstrb_r[0]
      & wdata_r[OTR_CAPT_B_BIT];

   // pin edges: a pin is a plain input sampled on aclk, so a pulse
   // must be seen low on one edge and high on the next
   assign cab_rise = rise_seen(a_side_capture_clock, cab_prev_r);
   assign cba_rise = rise_seen(b_side_capture_clock, cba_prev_r);

   // capture triggers ignore enable and selects
   assign load_a = cab_rise | sw_cap_a;
   assign load_b = cba_rise | sw_cap_b;

   // direction and enable decode
   // drive enable high isolates both ports whatever else is set
   assign drive_on = ~ctrl_r.drive_en_n;
   assign drive_b = drive_on & ctrl_r.direction;
   assign drive_a = drive_on & ~ctrl_r.direction;

   // source for each side: stored word or live opposite port; a new
   // load shows at once because the mux reads the register directly
   assign b_src = pick_src(ctrl_r.a_to_b_source_select,
      a_storage_register_r, port_a_lines_in);
   assign a_src = pick_src(ctrl_r.b_to_a_source_select,
      b_storage_register_r, port_b_lines_in);

   // port outputs, non-inverting; the far side must back off
   // wherever an oe bit is high, or the lines would fight
   assign port_b_lines_out = b_src;
   assign port_a_lines_out = a_src;
   assign port_b_lines_oe = {PORT_W{drive_b}};
   assign port_a_lines_oe = {PORT_W{drive_a}};

   // status word: registers and live port levels, sampled
   // when the read address is taken
   assign stat_word = {
      (8)'(port_b_lines_in),
      (8)'(port_a_lines_in),
      (8)'(b_storage_register_r),
      (8)'(a_storage_register_r)
   };

   // read address decode, taken live in the cycle of the handshake
   assign rd_ctrl_hit = s_axi_araddr == OTR_CTRL_OFS;
   assign rd_stat_hit = s_axi_araddr == OTR_STAT_OFS;
   assign rd_capt_hit = s_axi_araddr == OTR_CAPT_OFS;
   assign rd_mapped = rd_ctrl_hit | rd_stat_hit | rd_capt_hit;

   // read mux; the capture strobe register reads back as zero
   assign rd_word = rd_ctrl_hit ? {28'h0000000, ctrl_r} :
      rd_stat_hit ? stat_word : 32'h00000000;
   assign rresp_nxt = rd_mapped ? OTR_RESP_OKAY : OTR_RESP_SLVERR;

   // storage registers, deliberately without reset
   // so contents stay unknown until the first load
   always_ff @(posedge aclk) begin
      if (load_a) begin
         a_storage_register_r <= port_a_lines_in;
      end
      if (load_b) begin
         b_storage_register_r <= port_b_lines_in;
      end
      // otherwise both hold their contents
   end

   // capture clock samples, reset high so no false edge
   // a pin already high at release must fall before it counts
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cab_prev_r <= 1'b1;
         cba_prev_r <= 1'b1;
      end else begin
         cab_prev_r <= a_side_capture_clock;
         cba_prev_r <= b_side_capture_clock;
      end
   end

   // control register
   // resets to isolation so nothing drives before software asks
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= OTR_CTRL_RST;
      end else if (ctrl_we) begin
         ctrl_r <= ctrl_wr_val;
      end
   end

   // write address and data holding
   // address and data may come in either order; each half
   // is held until the pair is complete
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         awaddr_r <= 4'h0;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
      end else begin
         if (aw_take) begin
            aw_have_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end else if (wr_do) begin
            aw_have_r <= 1'b0;
         end
         if (w_take) begin
            w_have_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end else if (wr_do) begin
            w_have_r <= 1'b0;
         end
      end
   end

   // write response
   // no new write is taken while bvalid stands, so a write
   // completion and a response handshake never meet
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r <= OTR_RESP_OKAY;
      end else if (wr_do) begin
         bvalid_r <= 1'b1;
         bresp_r <= bresp_nxt;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // read response
   // arready stays low while rvalid stands, so no second read
   // can overwrite the data before it is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rresp_r <= OTR_RESP_OKAY;
         rdata_r <= 32'h00000000;
      end else if (ar_take) begin
         rvalid_r <= 1'b1;
         rresp_r <= rresp_nxt;
         rdata_r <= rd_word;
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // bus outputs
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp = rresp_r;
   assign s_axi_rdata = rdata_r;

endmodule

`default_nettype wire

// ---- sim/otr_transceiver_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module otr_transceiver_asserts #(
   parameter int PORT_W = 8
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // capture pins
   input wire logic a_side_capture_clock,
   input wire logic b_side_capture_clock,
   // port a lines
   input wire logic [PORT_W-1:0] port_a_lines_in,
   input wire logic [PORT_W-1:0] port_a_lines_out,
   input wire logic [PORT_W-1:0] port_a_lines_oe,
   // port b lines
   input wire logic [PORT_W-1:0] port_b_lines_in,
   input wire logic [PORT_W-1:0] port_b_lines_out,
   input wire logic [PORT_W-1:0] port_b_lines_oe
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // port drive
   AST_ONE_SIDE: assert property (
      !(|port_a_lines_oe && |port_b_lines_oe))
      else $error("both ports driven");
   AST_WHOLE: assert property (
      (port_a_lines_oe == '0 || &port_a_lines_oe)
      && (port_b_lines_oe == '0 || &port_b_lines_oe))
      else $error("split enable");
   AST_RST_IDLE: assert property (
      $rose(aresetn) |-> port_a_lines_oe == '0 && port_b_lines_oe == '0)
      else $error("driven after reset");
   // capture seen through a driven port
   AST_CAP_A: assert property (
      $rose(a_side_capture_clock) && &port_b_lines_oe
      ##1 &port_b_lines_oe && $stable(port_a_lines_in)
      |-> port_b_lines_out == $past(port_a_lines_in))
      else $error("b stale");
   AST_CAP_B: assert property (
      $rose(b_side_capture_clock) && &port_a_lines_oe
      ##1 &port_a_lines_oe && $stable(port_b_lines_in)
      |-> port_a_lines_out == $past(port_b_lines_in))
      else $error("a stale");
   // bus answers
   AST_W_ANS: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid)
      else $error("no write answer");
   AST_B_BLOCK: assert property (
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("taken while answering");
   AST_AR_ANS: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("no read answer");
   AST_R_DONE: assert property (
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer stuck");
endmodule
bind otr_transceiver otr_transceiver_asserts #(.PORT_W(PORT_W)) u_asserts (
   .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .s_axi_rready, .a_side_capture_clock, .b_side_capture_clock,
   .port_a_lines_in, .port_a_lines_out, .port_a_lines_oe, .port_b_lines_in,
   .port_b_lines_out, .port_b_lines_oe);
`default_nettype wire

// ---- sim/otr_bus_agent.sv ----
`timescale 1ns/1ps
`default_nettype none
module otr_bus_agent #(parameter int PORT_W = 8) (
   // agent values
   input wire logic [PORT_W-1:0] a_drv, b_drv,
   // device side
   input wire logic [PORT_W-1:0] a_out, a_oe, b_out, b_oe,
   // resolved lines
   output logic [PORT_W-1:0] a_line, b_line
);
   // agents back off wherever the device drives, else hold a level
   assign a_line = (a_oe & a_out) | (~a_oe & a_drv);
   assign b_line = (b_oe & b_out) | (~b_oe & b_drv);
endmodule
`default_nettype wire

// ---- sim/otr_transceiver_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module otr_transceiver_tb;
   import otr_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0, cap_a = 1'b0, cap_b = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic [1:0] bresp, rresp, rs;
   logic [7:0] pa = 8'h00, pb = 8'h00, a_in, a_out, a_oe, b_in, b_out, b_oe;
   logic [7:0] exp_b;
   int failures = 0, checks = 0, i;
   // clock
   always #4 aclk = ~aclk;
   otr_transceiver dut (
      .aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .a_side_capture_clock(cap_a), .b_side_capture_clock(cap_b),
      .port_a_lines_in(a_in), .port_a_lines_out(a_out), .port_a_lines_oe(a_oe),
      .port_b_lines_in(b_in), .port_b_lines_out(b_out), .port_b_lines_oe(b_oe));
   otr_bus_agent agent (.a_drv(pa), .b_drv(pb), .a_out, .a_oe, .b_out, .b_oe,
      .a_line(a_in), .b_line(b_in));
   // verdict
   task automatic finish_test();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic bound(input int n);
      if (n == 40) begin
         failures++;
         finish_test();
      end
   endtask
   task automatic chk(input logic [31:0] g, e);
      checks++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // bus write, waits for the answer
   task automatic wr(input logic [3:0] ad, input logic [31:0] d);
      int n;
      logic ha, hw, hb;
      @(posedge aclk);
      awaddr <= ad;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(negedge aclk);
         ha = awready;
         hw = wready;
         hb = bvalid;
         rs = bresp;
         @(posedge aclk);
         if (ha) awvalid <= 1'b0;
         if (hw) wvalid <= 1'b0;
         if (hb) break;
      end
      bready <= 1'b0;
      bound(n);
   endtask
   // bus read into rd and rs
   task automatic rd_reg(input logic [3:0] ad);
      int n;
      logic ha, hb;
      @(posedge aclk);
      araddr <= ad;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(negedge aclk);
         ha = arready;
         hb = rvalid;
         rd = rdata;
         rs = rresp;
         @(posedge aclk);
         if (ha) arvalid <= 1'b0;
         if (hb) break;
      end
      rready <= 1'b0;
      bound(n);
   endtask
   // one pulse on the capture pins
   task automatic cap(input logic a, b);
      @(posedge aclk);
      cap_a <= a;
      cap_b <= b;
      @(posedge aclk);
      cap_a <= 1'b0;
      cap_b <= 1'b0;
      @(negedge aclk);
   endtask
   // main sequence
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rd_reg(OTR_CTRL_OFS);
      chk(rd, 32'h1);
      chk(32'({a_oe, b_oe}), 32'h0);
      pa <= 8'h5a;
      pb <= 8'hc3;
      cap(1'b1, 1'b1);
      rd_reg(OTR_STAT_OFS);
      chk(rd, 32'hc35ac35a);
      pa <= 8'h96;
      pb <= 8'h3c;
      wr(OTR_CTRL_OFS, 32'hf);
      chk(32'({a_oe, b_oe}), 32'h0);
      rd_reg(OTR_STAT_OFS);
      chk(rd, 32'h3c96c35a);
      cap(1'b0, 1'b1);
      rd_reg(OTR_STAT_OFS);
      chk(rd, 32'h3c963c5a);
      pb <= 8'he1;
      for (i = 0; i < 8; i++) begin
         wr(OTR_CTRL_OFS, 32'(i * 2));
         exp_b = i[1] ? 8'h5a : 8'h96;
         chk(32'({a_oe, b_oe}), i[0] ? 32'hff : 32'hff00);
         if (i[0]) chk(32'(b_out), 32'(exp_b));
         else chk(32'(a_out), i[2] ? 32'h3c : 32'he1);
      end
      wr(OTR_CTRL_OFS, 32'h6);
      pa <= 8'ha5;
      cap(1'b1, 1'b0);
      chk(32'(b_out), 32'ha5);
      wr(OTR_CTRL_OFS, 32'h8);
      pb <= 8'h71;
      cap(1'b0, 1'b1);
      chk(32'(a_out), 32'h71);
      @(posedge aclk);
      pa <= 8'h00;
      cap(1'b1, 1'b0);
      rd_reg(OTR_STAT_OFS);
      chk(rd, 32'h71717171);
      wr(OTR_CTRL_OFS, 32'h2);
      pa <= 8'h3e;
      cap(1'b1, 1'b0);
      chk(32'(b_out), 32'h3e);
      rd_reg(OTR_STAT_OFS);
      chk(rd, 32'h3e3e713e);
      pa <= 8'h2d;
      wr(OTR_CAPT_OFS, 32'h3);
      rd_reg(OTR_STAT_OFS);
      chk(rd, 32'h2d2d2d2d);
      wstrb <= 4'h0;
      wr(OTR_CTRL_OFS, 32'h1);
      wstrb <= 4'hf;
      chk(32'({a_oe, b_oe}), 32'hff);
      wr(4'hc, 32'hf);
      chk(32'(rs), 32'(OTR_RESP_SLVERR));
      rd_reg(4'hc);
      chk(32'(rs), 32'(OTR_RESP_SLVERR));
      finish_test();
   end
endmodule
`default_nettype wire
